// [src/ledreg_pkg.sv]
// Shared constants and types for the LED driver serial register bank.
package ledreg_pkg;

	// Seven-bit serial slave address that the device answers to.
	localparam logic [6:0] SLAVE_ADDR = 7'h36;

	// Number of data bits in one serial byte.
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// Register offsets as seen over the serial link.
	localparam logic [7:0] OFS_GENERAL_CONTROL = 8'h10;
	localparam logic [7:0] OFS_MULTI_FUNCTION_PIN_CONTROL = 8'h80;
	localparam logic [7:0] OFS_DEDICATED_IO_CONTROL = 8'h81;
	localparam logic [7:0] OFS_PATTERN_BYTE_0 = 8'h90;
	localparam logic [7:0] OFS_PATTERN_BYTE_1 = 8'h91;
	localparam logic [7:0] OFS_PATTERN_BYTE_2 = 8'h92;
	localparam logic [7:0] OFS_PATTERN_BYTE_3 = 8'h93;
	localparam logic [7:0] OFS_MAIN_BRIGHTNESS = 8'hA0;
	localparam logic [7:0] OFS_SUB_BRIGHTNESS = 8'hB0;

	// Power-on values of the registers.
	localparam logic [7:0] RST_GENERAL_CONTROL = 8'hC0;
	localparam logic [7:0] RST_MULTI_FUNCTION_PIN_CONTROL = 8'hF8;
	localparam logic [7:0] RST_DEDICATED_IO_CONTROL = 8'hFC;
	localparam logic [7:0] RST_PATTERN_BYTE = 8'h00;
	localparam logic [7:0] RST_MAIN_BRIGHTNESS = 8'h80;
	localparam logic [7:0] RST_SUB_BRIGHTNESS = 8'h80;

	// Bits that are fixed at one and ignore writes.
	localparam logic [7:0] GC_FIXED_ONES = 8'hC0;
	localparam logic [7:0] IO_FIXED_ONES = 8'hFC;

	// Value returned for an offset that holds no register.
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Field positions inside the general control register.
	localparam int unsigned GC_MAIN_EN_BIT = 0;
	localparam int unsigned GC_SEC_EN_BIT = 1;
	localparam int unsigned GC_UNISON_BIT = 2;
	localparam int unsigned GC_RAMP_LSB = 3;
	localparam int unsigned GC_RAMP_MSB = 4;
	localparam int unsigned GC_PANEL_BIT = 5;

	// Top bit of the brightness level field; the bit above it is ignored.
	localparam int unsigned LEVEL_MSB = 6;

	// Protocol states of the serial slave, one-hot.
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_DEV_ADDR = 7'h02,
		ST_REG_ADDR = 7'h04,
		ST_DATA_IN = 7'h08,
		ST_ACK = 7'h10,
		ST_TX = 7'h20,
		ST_TX_ACK = 7'h40
	} ledreg_state_e;

endpackage : ledreg_pkg

// [src/ledreg_sync.sv]
// Two-flop synchroniser for levels and toggles entering a clock domain.
`timescale 1ns/1ps
module ledreg_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	// First stage; only the second stage reads it.
	logic [WIDTH-1:0] meta;

	// Refuse a width that has no bits to carry.
	if (WIDTH < 1) begin : g_bad_width
		$error("ledreg_sync needs WIDTH of at least one");
	end

	// Two stages in series on the destination clock.
	always_ff @(posedge clk_i) begin
		meta <= d_i;
		q_o <= meta;
	end

endmodule : ledreg_sync

// [src/ledreg_top.sv]
// Serial slave and register bank with control decode for the LED driver.
// Operation
// - Answer only to slave address 36h after START.
// - Bit after address: zero writes, one reads.
// - Second byte is pointer, third byte is stored.
// - Bytes are eight bits, MSB first, then acknowledge.
// - Device pulls data low through ninth pulse.
// - Registers are 8 bits with listed power-on values.
// - Bit 0 enables main sink, else high impedance.
// - Bit 1 enables secondary sink, else high impedance.
// - Unison bit makes main brightness drive both sinks.
// - Bits 3 and 4 select current ramp rate.
// - Bit 5 selects panel supply, feedback on secondary.
// - Bits 6 and 7 ignore writes, read one.
// - Analog on when any enable or panel bit.
// - Unison white mode: main enable switches both sinks.
// - Panel mode: secondary off, main follows enable.
// - Independent mode: each sink own enable, brightness.
// - Only low seven brightness bits set current.
`timescale 1ns/1ps
module ledreg_top (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic main_sink_on_o,
	output logic secondary_sink_on_o,
	output logic [6:0] main_level_o,
	output logic [6:0] secondary_level_o,
	output logic [1:0] ramp_rate_o,
	output logic panel_supply_mode_o,
	output logic analog_enable_o,
	output logic [7:0] multi_function_pin_control_o,
	output logic [7:0] dedicated_io_control_o,
	output logic [31:0] pattern_o
);

	// ---------------- Link domain ----------------

	// Reset as seen on the link clock.
	logic link_rst;
	// Synchronised serial clock and data levels.
	logic [1:0] pins_s;
	logic scl_s;
	logic sda_s;
	// Previous synchronised levels for edge detection.
	logic scl_q;
	logic sda_q;
	// Bus events decoded from the pin levels.
	logic start_ev;
	logic stop_ev;
	logic scl_rise;
	logic scl_fall;
	// Protocol state and the state that follows the acknowledge slot.
	ledreg_pkg::ledreg_state_e state;
	ledreg_pkg::ledreg_state_e ack_next;
	// Bit counter within a byte.
	logic [3:0] bit_cnt;
	// Receive shift register.
	logic [7:0] shift;
	// Transmit shift register.
	logic [7:0] tx_shift;
	// Register pointer loaded by the second byte of a transfer.
	logic [7:0] reg_ptr;
	// Request bundle towards the register domain, held until answered.
	logic req_tgl;
	logic req_we;
	logic [7:0] req_addr;
	logic [7:0] req_wdata;
	// Answer toggle as seen on the link clock, and its last value.
	logic ack_s;
	logic ack_seen;
	// Copy of the register that the pointer selects.
	logic [7:0] rd_buf;

	// ---------------- Register domain ----------------

	// Request toggle as seen on the reference clock, and its last value.
	logic req_s;
	logic req_seen;
	logic req_edge;
	// Answer step follows the request step by one cycle.
	logic rsp_go;
	// Answer toggle and the data it carries.
	logic ack_tgl;
	logic [7:0] rsp_data;
	// Register storage.
	logic [7:0] general_control;
	logic [7:0] main_brightness;
	logic [7:0] sub_brightness;
	logic [7:0] rd_mux;

	// Bring the reset into the link domain.
	ledreg_sync #(.WIDTH(1)) u_rst_sync (
		.clk_i(link_clk_i),
		.d_i(rst_i),
		.q_o(link_rst)
	);

	// Bring both serial pins into the link domain.
	ledreg_sync #(.WIDTH(2)) u_pin_sync (
		.clk_i(link_clk_i),
		.d_i({scl_i, sda_i}),
		.q_o(pins_s)
	);

	// Bring the answer toggle into the link domain.
	ledreg_sync #(.WIDTH(1)) u_ack_sync (
		.clk_i(link_clk_i),
		.d_i(ack_tgl),
		.q_o(ack_s)
	);

	// Bring the request toggle into the register domain.
	ledreg_sync #(.WIDTH(1)) u_req_sync (
		.clk_i(ref_clk_i),
		.d_i(req_tgl),
		.q_o(req_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	// Keep the previous pin levels so edges can be seen.
	always_ff @(posedge link_clk_i) begin
		scl_q <= scl_s;
		sda_q <= sda_s;
	end

	// START and STOP are data edges while the clock stays high.
	assign start_ev = scl_s && scl_q && sda_q && !sda_s;
	assign stop_ev = scl_s && scl_q && !sda_q && sda_s;
	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;

	// Output data level of the open-drain pin is always low; only the enable moves.
	always_ff @(posedge link_clk_i) begin
		sda_o <= 1'b0;
	end

	// Serial protocol engine, sampling on clock rise and driving after clock fall.
	always_ff @(posedge link_clk_i) begin
		if (link_rst) begin
			state <= ledreg_pkg::ST_IDLE;
			ack_next <= ledreg_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			tx_shift <= 8'h00;
			reg_ptr <= 8'h00;
			sda_oe_o <= 1'b0;
			req_tgl <= 1'b0;
			req_we <= 1'b0;
			req_addr <= 8'h00;
			req_wdata <= 8'h00;
		end else if (start_ev) begin
			// A START or repeated START always opens a new address byte.
			state <= ledreg_pkg::ST_DEV_ADDR;
			bit_cnt <= 4'h0;
			sda_oe_o <= 1'b0;
		end else if (stop_ev) begin
			// A STOP frees the bus and the pin.
			state <= ledreg_pkg::ST_IDLE;
			sda_oe_o <= 1'b0;
		end else begin
			case (state)
				ledreg_pkg::ST_DEV_ADDR, ledreg_pkg::ST_REG_ADDR, ledreg_pkg::ST_DATA_IN: begin
					if (scl_rise && bit_cnt < ledreg_pkg::BITS_PER_BYTE) begin
						// Eight bits shift in, most significant first.
						shift <= {shift[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == ledreg_pkg::BITS_PER_BYTE) begin
						bit_cnt <= 4'h0;
						if (state == ledreg_pkg::ST_DEV_ADDR) begin
							if (shift[7:1] == ledreg_pkg::SLAVE_ADDR) begin
								// Our address: acknowledge, then direction bit picks the path.
								sda_oe_o <= 1'b1;
								state <= ledreg_pkg::ST_ACK;
								if (shift[0]) begin
									ack_next <= ledreg_pkg::ST_TX;
								end else begin
									ack_next <= ledreg_pkg::ST_REG_ADDR;
								end
							end else begin
								// Another slave is addressed; stay off the bus until START.
								state <= ledreg_pkg::ST_IDLE;
							end
						end else if (state == ledreg_pkg::ST_REG_ADDR) begin
							// Second byte sets the pointer and fetches its contents.
							reg_ptr <= shift;
							req_we <= 1'b0;
							req_addr <= shift;
							req_tgl <= ~req_tgl;
							sda_oe_o <= 1'b1;
							state <= ledreg_pkg::ST_ACK;
							ack_next <= ledreg_pkg::ST_DATA_IN;
						end else begin
							// Data byte is sent for storing as its acknowledge begins.
							req_we <= 1'b1;
							req_addr <= reg_ptr;
							req_wdata <= shift;
							req_tgl <= ~req_tgl;
							sda_oe_o <= 1'b1;
							state <= ledreg_pkg::ST_ACK;
							ack_next <= ledreg_pkg::ST_DATA_IN;
						end
					end
				end
				ledreg_pkg::ST_ACK: begin
					// The master clocks the ninth pulse; at its falling edge release, or drive the first read bit.
					if (scl_fall) begin
						state <= ack_next;
						if (ack_next == ledreg_pkg::ST_TX) begin
							// First read bit goes out at once, low only for a zero.
							tx_shift <= rd_buf;
							sda_oe_o <= ~rd_buf[7];
							bit_cnt <= 4'h1;
						end else begin
							sda_oe_o <= 1'b0;
						end
					end
				end
				ledreg_pkg::ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt == ledreg_pkg::BITS_PER_BYTE) begin
							// Hand the line to the master for its acknowledge.
							sda_oe_o <= 1'b0;
							state <= ledreg_pkg::ST_TX_ACK;
						end else begin
							// Next bit, most significant first.
							sda_oe_o <= ~tx_shift[6];
							tx_shift <= {tx_shift[6:0], 1'b0};
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				ledreg_pkg::ST_TX_ACK: begin
					if (scl_rise && sda_s) begin
						// No acknowledge from the master ends the read.
						state <= ledreg_pkg::ST_IDLE;
					end else if (scl_fall) begin
						// Acknowledged: send the same register again.
						tx_shift <= rd_buf;
						sda_oe_o <= ~rd_buf[7];
						bit_cnt <= 4'h1;
						state <= ledreg_pkg::ST_TX;
					end
				end
				ledreg_pkg::ST_IDLE: begin
					// Wait for a START; the pin stays released.
					sda_oe_o <= 1'b0;
				end
				default: begin
					state <= ledreg_pkg::ST_IDLE;
					sda_oe_o <= 1'b0;
				end
			endcase
		end
	end

	// Capture the register contents returned for each request.
	always_ff @(posedge link_clk_i) begin
		if (link_rst) begin
			ack_seen <= 1'b0;
			rd_buf <= 8'h00;
		end else begin
			ack_seen <= ack_s;
			// The answer data is held still while its toggle is in flight.
			if (ack_s != ack_seen) begin
				rd_buf <= rsp_data;
			end
		end
	end

	// ---------------- Register domain logic ----------------

	// A change of the request toggle marks a new, stable request bundle.
	assign req_edge = req_s ^ req_seen;

	// Track the request toggle and schedule the answer.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			req_seen <= 1'b0;
			rsp_go <= 1'b0;
		end else begin
			req_seen <= req_s;
			rsp_go <= req_edge;
		end
	end

	// Registers with power-on values; fixed bits stay one whatever is written.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			general_control <= ledreg_pkg::RST_GENERAL_CONTROL;
			multi_function_pin_control_o <= ledreg_pkg::RST_MULTI_FUNCTION_PIN_CONTROL;
			dedicated_io_control_o <= ledreg_pkg::RST_DEDICATED_IO_CONTROL;
			pattern_o <= {4{ledreg_pkg::RST_PATTERN_BYTE}};
			main_brightness <= ledreg_pkg::RST_MAIN_BRIGHTNESS;
			sub_brightness <= ledreg_pkg::RST_SUB_BRIGHTNESS;
		end else if (req_edge && req_we) begin
			// A write request stores into the addressed register only.
			case (req_addr)
				ledreg_pkg::OFS_GENERAL_CONTROL: begin
					general_control <= req_wdata | ledreg_pkg::GC_FIXED_ONES;
				end
				ledreg_pkg::OFS_MULTI_FUNCTION_PIN_CONTROL: begin
					multi_function_pin_control_o <= req_wdata;
				end
				ledreg_pkg::OFS_DEDICATED_IO_CONTROL: begin
					dedicated_io_control_o <= req_wdata | ledreg_pkg::IO_FIXED_ONES;
				end
				ledreg_pkg::OFS_PATTERN_BYTE_0: begin
					pattern_o[7:0] <= req_wdata;
				end
				ledreg_pkg::OFS_PATTERN_BYTE_1: begin
					pattern_o[15:8] <= req_wdata;
				end
				ledreg_pkg::OFS_PATTERN_BYTE_2: begin
					pattern_o[23:16] <= req_wdata;
				end
				ledreg_pkg::OFS_PATTERN_BYTE_3: begin
					pattern_o[31:24] <= req_wdata;
				end
				ledreg_pkg::OFS_MAIN_BRIGHTNESS: begin
					main_brightness <= req_wdata;
				end
				ledreg_pkg::OFS_SUB_BRIGHTNESS: begin
					sub_brightness <= req_wdata;
				end
				default: begin
					// Writes to empty offsets are dropped.
				end
			endcase
		end
	end

	// Select the register that a request addresses.
	always_comb begin
		case (req_addr)
			ledreg_pkg::OFS_GENERAL_CONTROL: rd_mux = general_control;
			ledreg_pkg::OFS_MULTI_FUNCTION_PIN_CONTROL: rd_mux = multi_function_pin_control_o;
			ledreg_pkg::OFS_DEDICATED_IO_CONTROL: rd_mux = dedicated_io_control_o;
			ledreg_pkg::OFS_PATTERN_BYTE_0: rd_mux = pattern_o[7:0];
			ledreg_pkg::OFS_PATTERN_BYTE_1: rd_mux = pattern_o[15:8];
			ledreg_pkg::OFS_PATTERN_BYTE_2: rd_mux = pattern_o[23:16];
			ledreg_pkg::OFS_PATTERN_BYTE_3: rd_mux = pattern_o[31:24];
			ledreg_pkg::OFS_MAIN_BRIGHTNESS: rd_mux = main_brightness;
			ledreg_pkg::OFS_SUB_BRIGHTNESS: rd_mux = sub_brightness;
			default: rd_mux = ledreg_pkg::UNMAPPED_READ;
		endcase
	end

	// One cycle after a request, return the current contents and flip the answer.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ack_tgl <= 1'b0;
			rsp_data <= 8'h00;
		end else if (rsp_go) begin
			rsp_data <= rd_mux;
			ack_tgl <= ~ack_tgl;
		end
	end

	// Decode the general control register into sink and supply controls.
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			main_sink_on_o <= 1'b0;
			secondary_sink_on_o <= 1'b0;
			main_level_o <= 7'h00;
			secondary_level_o <= 7'h00;
			ramp_rate_o <= 2'h0;
			panel_supply_mode_o <= 1'b0;
			analog_enable_o <= 1'b0;
		end else begin
			// Main sink follows its enable in every mode; off means high impedance.
			main_sink_on_o <= general_control[ledreg_pkg::GC_MAIN_EN_BIT];
			if (general_control[ledreg_pkg::GC_PANEL_BIT]) begin
				// Panel supply: the secondary pin is voltage feedback, sink kept off.
				secondary_sink_on_o <= 1'b0;
			end else if (general_control[ledreg_pkg::GC_UNISON_BIT]) begin
				// Unison: the main enable switches both sinks.
				secondary_sink_on_o <= general_control[ledreg_pkg::GC_MAIN_EN_BIT];
			end else begin
				// Independent: secondary sink obeys its own enable.
				secondary_sink_on_o <= general_control[ledreg_pkg::GC_SEC_EN_BIT];
			end
			// Only the low seven bits set a level; the top bit is ignored.
			main_level_o <= main_brightness[ledreg_pkg::LEVEL_MSB:0];
			if (general_control[ledreg_pkg::GC_UNISON_BIT]) begin
				// Unison ignores the sub brightness register.
				secondary_level_o <= main_brightness[ledreg_pkg::LEVEL_MSB:0];
			end else begin
				secondary_level_o <= sub_brightness[ledreg_pkg::LEVEL_MSB:0];
			end
			// Ramp rate applies to both sinks after brightness changes.
			ramp_rate_o <= general_control[ledreg_pkg::GC_RAMP_MSB:ledreg_pkg::GC_RAMP_LSB];
			panel_supply_mode_o <= general_control[ledreg_pkg::GC_PANEL_BIT];
			// Analog stays on while any enable or the panel bit is set.
			analog_enable_o <= general_control[ledreg_pkg::GC_MAIN_EN_BIT]
				| general_control[ledreg_pkg::GC_SEC_EN_BIT]
				| general_control[ledreg_pkg::GC_PANEL_BIT];
		end
	end

endmodule : ledreg_top

// [testbench/ledreg_asserts.sv]
// Port-level concurrent checks for the LED driver serial register bank.
`timescale 1ns/1ps
module ledreg_asserts (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic link_clk_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic main_sink_on_o,
	input wire logic secondary_sink_on_o,
	input wire logic [6:0] main_level_o,
	input wire logic [6:0] secondary_level_o,
	input wire logic [1:0] ramp_rate_o,
	input wire logic panel_supply_mode_o,
	input wire logic analog_enable_o,
	input wire logic [7:0] multi_function_pin_control_o,
	input wire logic [7:0] dedicated_io_control_o
);
	// The data pin is open drain, so the driven value is always low.
	AST_OPEN_DRAIN: assert property (@(posedge link_clk_i) disable iff (rst_i)
		sda_o == 1'b0) else $error("sda_o is not low");
	// An acknowledge or data low, once driven, stands well beyond a few link cycles.
	AST_ACK_STANDS: assert property (@(posedge link_clk_i) disable iff (rst_i)
		$rose(sda_oe_o) |-> sda_oe_o [*8]) else $error("sda_oe_o dropped too soon");
	// The device moves the data line only while the serial clock is low.
	AST_SDA_MOVES_LOW: assert property (@(posedge link_clk_i) disable iff (rst_i)
		$changed(sda_oe_o) |-> !scl_i) else $error("sda_oe_o moved with scl high");
	// Right after reset the pin control and io control outputs show their power-on values.
	AST_RESET_VALUES: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$fell(rst_i) |-> multi_function_pin_control_o == 8'hF8
		&& dedicated_io_control_o == 8'hFC) else $error("power-on values wrong");
	// Right after reset both sinks are off and the analog part is idle.
	AST_RESET_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$fell(rst_i) |-> !main_sink_on_o && !secondary_sink_on_o && !analog_enable_o)
		else $error("sinks on after reset");
	// Unused input/output control bits always read as one.
	AST_IO_FIXED_ONES: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		dedicated_io_control_o[7:2] == 6'h3F) else $error("io control high bits not one");
	// In panel mode the secondary pin is feedback, never a sink.
	AST_PANEL_SEC_OFF: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		panel_supply_mode_o |-> !secondary_sink_on_o) else $error("secondary on in panel mode");
	// Any sink or panel mode needs the analog circuitry on.
	AST_ANALOG_ON: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		main_sink_on_o || secondary_sink_on_o || panel_supply_mode_o |-> analog_enable_o)
		else $error("analog off while active");
	// Decode only changes while a data byte is being acknowledged.
	AST_DECODE_AT_ACK: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$changed({ramp_rate_o, panel_supply_mode_o, main_level_o, secondary_level_o})
		|-> sda_oe_o) else $error("decode changed outside acknowledge");
endmodule : ledreg_asserts

bind ledreg_top ledreg_asserts u_ledreg_asserts (
	.ref_clk_i(ref_clk_i),
	.rst_i(rst_i),
	.link_clk_i(link_clk_i),
	.scl_i(scl_i),
	.sda_o(sda_o),
	.sda_oe_o(sda_oe_o),
	.main_sink_on_o(main_sink_on_o),
	.secondary_sink_on_o(secondary_sink_on_o),
	.main_level_o(main_level_o),
	.secondary_level_o(secondary_level_o),
	.ramp_rate_o(ramp_rate_o),
	.panel_supply_mode_o(panel_supply_mode_o),
	.analog_enable_o(analog_enable_o),
	.multi_function_pin_control_o(multi_function_pin_control_o),
	.dedicated_io_control_o(dedicated_io_control_o)
);

// [testbench/ledreg_host_model.sv]
// Behavioural serial bus master that drives the device's clock and data pins.
`timescale 1ns/1ps
module ledreg_host_model (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_low_o
);
	// The clock idles high and the data line is released to its pull-up.
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end
	// One third of a bit time is four reference cycles, all pin moves land on an edge.
	task automatic half();
		repeat (4) @(posedge clk_i);
	endtask : half
	// Start, or repeated start, is data falling while the clock is high.
	task automatic start();
		half();
		sda_low_o <= 1'b0;
		half();
		scl_o <= 1'b1;
		half();
		sda_low_o <= 1'b1;
		half();
		scl_o <= 1'b0;
	endtask : start
	// Stop is data rising while the clock is high; the clock then stands still.
	task automatic stop();
		half();
		sda_low_o <= 1'b1;
		half();
		scl_o <= 1'b1;
		half();
		sda_low_o <= 1'b0;
		half();
	endtask : stop
	// Data changes only with the clock low, then one clock pulse.
	task automatic bit_out(input logic b);
		half();
		sda_low_o <= !b;
		half();
		scl_o <= 1'b1;
		half();
		scl_o <= 1'b0;
	endtask : bit_out
	// The line is released and sampled near the end of the high phase.
	task automatic bit_in(output logic b);
		half();
		sda_low_o <= 1'b0;
		half();
		scl_o <= 1'b1;
		half();
		b = sda_i;
		scl_o <= 1'b0;
	endtask : bit_in
	// Eight bits most significant first, then a released ninth pulse for the ack.
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bit_out(b[i]);
		end
		bit_in(a);
		ack = !a;
	endtask : send_byte
	// Reads eight bits and answers with an ack (low) or a nack (released).
	task automatic recv_byte(input logic ack, output logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bit_in(d[i]);
		end
		bit_out(!ack);
	endtask : recv_byte
endmodule : ledreg_host_model

// [testbench/testbench.sv]
// Self-checking bench for the LED driver serial register bank.
`timescale 1ns/1ps
module testbench;
	logic ref_clk_i, link_clk_i, rst_i, scl, host_low, sda_wire, sda_o, sda_oe_o;
	logic main_on, sec_on, panel, analog;
	logic [6:0] main_lvl, sec_lvl;
	logic [1:0] ramp;
	logic [7:0] mfpc, dio, rdata, gc, bm, bs;
	logic [31:0] pattern, seed;
	int err_total, cmp_count;
	// Offsets and their power-on values, in the same order.
	localparam logic [7:0] OFS_TAB [9] = '{8'h10, 8'hA0, 8'hB0, 8'h80, 8'h81, 8'h90, 8'h91,
		8'h92, 8'h93};
	localparam logic [7:0] RST_TAB [9] = '{8'hC0, 8'h80, 8'h80, 8'hF8, 8'hFC, 8'h00, 8'h00,
		8'h00, 8'h00};
	// The data wire has a pull-up and is low when either side pulls it.
	assign sda_wire = !(host_low || (sda_oe_o && !sda_o));
	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = !ref_clk_i;
	end
	// The link clock runs free at 6 ns with an unrelated phase.
	initial begin
		link_clk_i = 1'b0;
		#1.3;
		forever #3 link_clk_i = !link_clk_i;
	end
	ledreg_top u_ledreg_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
		.scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.main_sink_on_o(main_on), .secondary_sink_on_o(sec_on), .main_level_o(main_lvl),
		.secondary_level_o(sec_lvl), .ramp_rate_o(ramp), .panel_supply_mode_o(panel),
		.analog_enable_o(analog), .multi_function_pin_control_o(mfpc),
		.dedicated_io_control_o(dio), .pattern_o(pattern));
	ledreg_host_model u_host (.clk_i(ref_clk_i), .sda_i(sda_wire), .scl_o(scl),
		.sda_low_o(host_low));
	// Galois shift register that supplies the random values.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction : lfsr
	// Expected {main on, sec on, main level, sec level, ramp, panel, analog}.
	function automatic logic [19:0] exp_decode(input logic [7:0] g, b_m, b_s);
		logic s;
		s = g[5] ? 1'b0 : (g[2] ? g[0] : g[1]);
		return {g[0], s, b_m[6:0], (g[2] ? b_m[6:0] : b_s[6:0]), g[4:3], g[5], g[0] | g[1] | g[5]};
	endfunction : exp_decode
	// Compares and counts; a mismatch is printed at once.
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	// Prints the verdict and ends the run.
	task automatic end_of_test();
		if (err_total == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : end_of_test
	// Write transfer: address byte; if it is acknowledged, pointer and data, each acknowledged.
	task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] d);
		logic a;
		u_host.start();
		u_host.send_byte({dev, 1'b0}, a);
		check("addr ack", 32'(dev == ledreg_pkg::SLAVE_ADDR), 32'(a));
		if (a) begin
			u_host.send_byte(ofs, a);
			check("ofs ack", 32'h1, 32'(a));
			u_host.send_byte(d, a);
			check("data ack", 32'h1, 32'(a));
		end
		u_host.stop();
		repeat (20) @(posedge ref_clk_i);
	endtask : wr
	// Read transfer: pointer write, repeated start, one byte closed by nack.
	task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
		logic a;
		u_host.start();
		u_host.send_byte({ledreg_pkg::SLAVE_ADDR, 1'b0}, a);
		u_host.send_byte(ofs, a);
		u_host.start();
		u_host.send_byte({ledreg_pkg::SLAVE_ADDR, 1'b1}, a);
		check("read ack", 32'h1, 32'(a));
		u_host.recv_byte(1'b0, d);
		u_host.stop();
		repeat (20) @(posedge ref_clk_i);
	endtask : rd
	// Reset for ten cycles, then check power-on state at the ports and over the bus.
	task automatic do_reset();
		rst_i <= 1'b1;
		repeat (10) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (20) @(posedge ref_clk_i);
		check("decode", 32'(exp_decode(8'h00, 8'h00, 8'h00)), 32'({main_on, sec_on, main_lvl,
			sec_lvl, ramp, panel, analog}));
		check("ports", {24'h0, 8'hF8}, {24'h0, mfpc});
		check("pattern", 32'h0, pattern);
		rd(8'h10, rdata);
		check("gc after reset", 32'hC0, 32'(rdata));
	endtask : do_reset
	// Hang guard.
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		err_total++;
		end_of_test();
	end
	// Main sequence.
	initial begin
		seed = 32'h00012526;
		err_total = 0;
		cmp_count = 0;
		rst_i = 1'b1;
		do_reset();
		for (int i = 0; i < 9; i++) begin
			rd(OFS_TAB[i], rdata);
			check("reset value", 32'(RST_TAB[i]), 32'(rdata));
		end
		wr(7'h37, 8'h10, 8'h27);
		rd(8'h10, rdata);
		check("gc after foreign addr", 32'hC0, 32'(rdata));
		rd(8'h55, rdata);
		check("unmapped read", 32'h0, 32'(rdata));
		// Every enable, unison and panel combination, random ramp and levels.
		for (int i = 0; i < 16; i++) begin
			seed = lfsr(seed);
			gc = seed[7:0];
			{gc[5], gc[2], gc[1], gc[0]} = 4'(i);
			bm = seed[15:8];
			bs = seed[23:16];
			wr(ledreg_pkg::SLAVE_ADDR, 8'h10, gc);
			wr(ledreg_pkg::SLAVE_ADDR, 8'hA0, bm);
			wr(ledreg_pkg::SLAVE_ADDR, 8'hB0, bs);
			check("decode", 32'(exp_decode(gc, bm, bs)), 32'({main_on, sec_on, main_lvl,
				sec_lvl, ramp, panel, analog}));
			rd(8'h10, rdata);
			check("gc readback", 32'(gc | 8'hC0), 32'(rdata));
		end
		// Pattern, pin control and io control storage.
		for (int i = 3; i < 9; i++) begin
			seed = lfsr(seed);
			wr(ledreg_pkg::SLAVE_ADDR, OFS_TAB[i], seed[7:0]);
			if (i == 3) check("pin ctrl", 32'(seed[7:0]), 32'(mfpc));
			if (i == 4) check("io ctrl", 32'(seed[7:0] | 8'hFC), 32'(dio));
			if (i > 4) check("pattern", 32'(seed[7:0]), 32'(pattern[8*(i-5) +: 8]));
		end
		do_reset();
		end_of_test();
	end
endmodule : testbench
